// File: pkg/misc_exec_regs.vh
/*
 constants for the misc instruction execute block: opcodes, masks, bit positions, reset values.
 assumes the includer uses 14-bit instruction words and 8-bit data.
*/
`ifndef MISC_EXEC_REGS_VH
`define MISC_EXEC_REGS_VH
`define OPC_CLEAR_WORKING 14'h0103
`define OPC_INTERRUPT_RETURN 14'h0009
`define OPC_LOAD_OPTION 14'h0062
`define OPC_IDLE_VALUE 14'h0000
`define OPC_IDLE_MASK 14'h3f9f
`define GIE_BIT 3'h7
`define WORKING_RESET 8'h00
`define OPTION_RESET 8'hff
`define INTERRUPT_CONTROL_REG_RESET 8'h00
`define RETURN_CYCLES 2'h2
`endif

// File: hdl/misc_instruction_execute.v
/*
 decode and execute of four no-operand instructions: clear working register, idle,
 interrupt return and load option register.
 assumes the fetch stage presents one word per instr_valid pulse and honours instr_ready;
 the stack pop and the program counter live outside and follow the pop/load strobes.
*/
// Contract
// - the clear-working word zeroes the working register and sets the zero flag in one cycle.
// - the interrupt-return word pops the stack and loads the popped top entry into the program counter.
// - interrupt return sets the global interrupt enable, bit 7 of the interrupt control register.
// - interrupt return takes two cycles and leaves every status flag alone.
// - the load-option word copies the working register into the option register in one cycle, flags untouched.
// - the option register is also read and written directly as an ordinary register.
`timescale 1ns/10ps
`include "misc_exec_regs.vh"
module misc_instruction_execute
(
   input wire core_clk,
   input wire rst_b,
   input wire instr_valid,
   input wire [13:0] instr_word,
   output wire instr_ready,
   input wire option_wr,
   input wire [7:0] option_wdata,
   input wire working_wr,
   input wire [7:0] working_wdata,
   input wire interrupt_control_reg_wr,
   input wire [7:0] interrupt_control_reg_wdata,
   input wire [12:0] stack_top_entry,
   output reg stack_pop,
   output reg pc_load,
   output reg [12:0] pc_load_value,
   output reg pc_advance,
   output reg unknown_op,
   output reg [7:0] working_reg,
   output reg zero_flag,
   output reg [7:0] option_reg,
   output reg [7:0] interrupt_control_reg
);

   localparam st_idle = 1'b0;
   localparam st_return2 = 1'b1;

   reg state;
   wire is_clear;
   wire is_return;
   wire is_option;
   wire is_idle;
   wire take;

   // second cycle of the return stalls the fetch stage
   assign instr_ready = (state == st_idle);
   assign take = instr_valid && instr_ready;
   assign is_clear = (instr_word == `OPC_CLEAR_WORKING);
   assign is_return = (instr_word == `OPC_INTERRUPT_RETURN);
   assign is_option = (instr_word == `OPC_LOAD_OPTION);
   assign is_idle = ((instr_word & `OPC_IDLE_MASK) == `OPC_IDLE_VALUE);

   always @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         state <= st_idle;
         stack_pop <= 1'b0;
         pc_load <= 1'b0;
         pc_load_value <= 13'h0000;
         pc_advance <= 1'b0;
         unknown_op <= 1'b0;
         working_reg <= `WORKING_RESET;
         zero_flag <= 1'b0;
         option_reg <= `OPTION_RESET;
         interrupt_control_reg <= `INTERRUPT_CONTROL_REG_RESET;
      end
      else
      begin
         stack_pop <= 1'b0;
         pc_load <= 1'b0;
         pc_advance <= 1'b0;
         unknown_op <= 1'b0;
         // direct writes first; instruction effects in the same cycle take priority
         if (option_wr)
            option_reg <= option_wdata;
         if (working_wr)
            working_reg <= working_wdata;
         if (interrupt_control_reg_wr)
            interrupt_control_reg <= interrupt_control_reg_wdata;
         case (state)
            st_idle:
            begin
               if (take)
               begin
                  if (is_clear)
                  begin
                     working_reg <= `WORKING_RESET;
                     zero_flag <= 1'b1;
                     pc_advance <= 1'b1;
                  end
                  else if (is_return)
                  begin
                     stack_pop <= 1'b1;
                     state <= st_return2;
                  end
                  else if (is_option)
                  begin
                     option_reg <= working_reg;
                     pc_advance <= 1'b1;
                  end
                  else if (is_idle)
                     pc_advance <= 1'b1;
                  else
                     unknown_op <= 1'b1;
               end
            end
            st_return2:
            begin
               // stack top is sampled on the same edge the outside stack applies the pop, so the popped entry is loaded
               pc_load <= 1'b1;
               pc_load_value <= stack_top_entry;
               interrupt_control_reg[`GIE_BIT] <= 1'b1;
               state <= st_idle;
            end
            default:
               state <= st_idle;
         endcase
      end
   end

endmodule // misc_instruction_execute

// File: tb/stack_model.sv
/* return stack model: offers the top entry; assumes one pop per stack_pop pulse */
`timescale 1ns/10ps
module stack_model(input wire core_clk, input wire stack_pop, output reg [12:0] stack_top_entry);
   initial stack_top_entry = 13'h0abc;
   // each pop exposes a different entry, so a stale sample shows
   always @(posedge core_clk) if (stack_pop) stack_top_entry <= stack_top_entry - 13'h0001;
endmodule // stack_model

// File: tb/misc_props.sv
/* checker for the execute block; assumes binding to its top ports */
`timescale 1ns/10ps
module misc_props(input wire core_clk, rst_b, instr_valid, instr_ready, stack_pop, pc_load, pc_advance,
   zero_flag, option_wr, input wire [13:0] instr_word, input wire [7:0] working_reg, option_reg,
   interrupt_control_reg, option_wdata);
   wire tk = instr_valid && instr_ready;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_clear_sets_zero: assert property (tk && instr_word == 14'h0103 |=> working_reg == 8'h00 && zero_flag)
      else $error("clear failed");
   a_return_pops: assert property (tk && instr_word == 14'h0009 |=> stack_pop ##1 pc_load)
      else $error("return pop failed");
   a_return_enables: assert property (tk && instr_word == 14'h0009 |=> ##1 interrupt_control_reg[7])
      else $error("enable not set");
   a_return_two_cycles: assert property (tk && instr_word == 14'h0009 |=> !instr_ready && $stable(zero_flag)
      ##1 instr_ready && $stable(zero_flag)) else $error("return timing");
   a_load_option: assert property (tk && instr_word == 14'h0062 |=> option_reg == $past(working_reg))
      else $error("option load failed");
   a_direct_option: assert property (option_wr && !tk |=> option_reg == $past(option_wdata))
      else $error("direct write failed");
   a_idle_advances: assert property (tk && (instr_word & 14'h3f9f) == 14'h0000 |=> pc_advance && !stack_pop)
      else $error("idle failed");
endmodule // misc_props
bind misc_instruction_execute misc_props p(.*);

// File: tb/testbench.sv
/* self-checking bench for the execute block; assumes stack_model on the far side */
`timescale 1ns/10ps
module testbench;
   reg core_clk = 0, rst_b = 0, instr_valid = 0, option_wr = 0, working_wr = 0;
   reg [13:0] instr_word = 14'h0000;
   reg [7:0] option_wdata = 8'h00, working_wdata = 8'h00;
   wire instr_ready, stack_pop, pc_load, pc_advance, unknown_op, zero_flag;
   wire [12:0] stack_top_entry, pc_load_value;
   wire [7:0] working_reg, option_reg, interrupt_control_reg;
   integer num_errors = 0, checked = 0, cycles = 0, i;
   reg [15:0] rows [0:3];
   misc_instruction_execute DUT(.interrupt_control_reg_wr(1'b0), .interrupt_control_reg_wdata(8'h00), .*);
   stack_model m(.core_clk(core_clk), .stack_pop(stack_pop), .stack_top_entry(stack_top_entry));
   initial forever #12.5 core_clk = ~core_clk;
   task chk(input [12:0] seen, input [12:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin num_errors = num_errors + 1; $display("ERROR %0t %h %h", $time, seen, exp); end
      end
   endtask
   task stop_test;
      begin
         $display("errors %0d checks %0d", num_errors, checked);
         if (num_errors == 0 && checked > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task send(input [13:0] w);
      begin
         @(posedge core_clk) instr_valid <= 1; instr_word <= w;
         @(posedge core_clk) instr_valid <= 0; #1;
      end
   endtask
   task put(input o, input [7:0] d);
      begin
         @(posedge core_clk) option_wr <= o; working_wr <= !o; option_wdata <= d; working_wdata <= d;
         @(posedge core_clk) option_wr <= 0; working_wr <= 0; #1;
      end
   endtask
   // hang guard, well above the few dozen cycles needed
   always @(posedge core_clk) begin cycles = cycles + 1; if (cycles == 400) begin num_errors = num_errors + 1; stop_test; end end
   initial begin
      rows[0] = 16'h8000; rows[1] = 16'h8060; rows[2] = 16'h8103; rows[3] = 16'h4001;
      repeat (6) @(posedge core_clk);
      rst_b <= 1;
      #1 chk(option_reg, 13'h00ff);
      for (i = 0; i < 4; i = i + 1) begin send(rows[i][13:0]); chk({pc_advance, unknown_op}, rows[i][15:14]); end
      put(0, 8'h5a);
      send(14'h0103);
      chk({working_reg, zero_flag}, 13'h0001);
      put(0, 8'h3c);
      send(14'h0062);
      chk(option_reg, 13'h003c);
      put(1, 8'ha5);
      chk(option_reg, 13'h00a5);
      send(14'h0009);
      chk({stack_pop, instr_ready}, 13'h0002);
      @(posedge core_clk) #1 chk({pc_load, interrupt_control_reg[7]}, 13'h0003);
      chk(pc_load_value, 13'h0abc);
      stop_test;
   end
endmodule // testbench
